// ==== hdl/cwc_top.sv ====
// Purpose: Eight compare channels with waveform outputs over APB
// Assumes: CLK is the base timer count clock; pins synchronous
// Notes:   Gate and filter fields are stored but not applied
//
// Notes on behaviour
// - each channel acts when timer equals compare
// - shape field picks single, phase, set/reset
// - function select 0 means waveform generation
// - function select 1 means time measurement
// - enable bit starts and stops the output
// - single phase: high on match, low at zero
// - free run gives period 65536 clocks
// - channel 0 match clears timer if chosen
// - reload match clears timer if chosen
// - cleared timer gives period n plus two
// - each match sets that channel's request flag
// - initial level bit sets starting output level
// - polarity bit inverts the output waveform
// - refresh bit picks when compare value loads
// - channels six, seven divide capture triggers
// - capture setup: edge, filter, gate, divider
`timescale 1ns/1ns
`default_nettype none
module cwc_top (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] TRIGGER_INPUT_PIN,
  output logic [7:0] WAVE_OUTPUT_PIN,
  output logic IRQ
);
  logic [15:0] cmp_buf_r [8];
  logic [15:0] cmp_act_r [8];
  logic [15:0] cfg_r [8];
  logic [7:0] fsel_r;
  logic [7:0] fen_r;
  logic [3:0] btc_r;
  logic [15:0] reload_r;
  logic [15:0] cnt_r;
  logic clr_pend_r;
  logic [7:0] div6_r;
  logic [7:0] div7_r;
  logic [31:0] rdata_nxt;
  logic err_nxt;
  logic setup;
  logic wr_en;
  logic [2:0] idx;
  logic [7:0] evt;
  logic [7:0] match;
  logic [7:0] flags;
  logic [7:0] mask;
  logic irq_w;
  logic sel_ch0;
  logic sel_rld;
  logic tmr_hit;
  logic run;

  cwc_ch_if chb [8] ();

  // True when the address falls in a bank of eight word registers
  function automatic logic in_bank(input logic [7:0] a,
      input logic [7:0] base);
    in_bank = (a[7:5] == base[7:5]) && (a[1:0] == 2'b00);
  endfunction

  // True for a write in the access phase of one exact register
  function automatic logic wr_at(input logic we, input logic [7:0] a,
      input logic [7:0] off);
    wr_at = we && (a == off);
  endfunction

  // ------------------------------------------------------------
  // APB handshake
  // ------------------------------------------------------------
  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PWRITE & PREADY;
  assign idx = PADDR[4:2];

  // Ready one cycle after setup: every transfer has no wait state
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= setup;
    end
  end

  // Read data and error latched in setup, held through access
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA <= PWRITE ? 32'h0000_0000 : rdata_nxt;
      PSLVERR <= err_nxt;
    end
  end

  // Read multiplexer; unmapped words read zero and flag an error
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (in_bank(PADDR, cwc_pkg::OFF_CMP0)) begin
      rdata_nxt[15:0] = cmp_buf_r[idx];
    end else if (in_bank(PADDR, cwc_pkg::OFF_CFG0)) begin
      rdata_nxt[15:0] = cfg_r[idx];
    end else begin
      case (PADDR)
        cwc_pkg::OFF_FSEL: rdata_nxt[7:0] = fsel_r;
        cwc_pkg::OFF_FEN: rdata_nxt[7:0] = fen_r;
        cwc_pkg::OFF_IRQF: rdata_nxt[7:0] = flags;
        cwc_pkg::OFF_IMSK: rdata_nxt[7:0] = mask;
        cwc_pkg::OFF_BTC: rdata_nxt[3:0] = btc_r;
        cwc_pkg::OFF_RLD: rdata_nxt[15:0] = reload_r;
        cwc_pkg::OFF_DIV6: rdata_nxt[7:0] = div6_r;
        cwc_pkg::OFF_DIV7: rdata_nxt[7:0] = div7_r;
        cwc_pkg::OFF_CNT: rdata_nxt[15:0] = cnt_r;
        default: err_nxt = 1'b1;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Global control registers
  // ------------------------------------------------------------
  // Function select and enable, one bit per channel
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      fsel_r <= cwc_pkg::BYTE_RST;
      fen_r <= cwc_pkg::BYTE_RST;
    end else begin
      if (wr_at(wr_en, PADDR, cwc_pkg::OFF_FSEL)) begin
        fsel_r <= PWDATA[7:0];
      end
      if (wr_at(wr_en, PADDR, cwc_pkg::OFF_FEN)) begin
        fen_r <= PWDATA[7:0];
      end
    end
  end

  // Timer clear selection and reload value
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      btc_r <= cwc_pkg::BTC_RST;
      reload_r <= cwc_pkg::RLD_RST;
    end else begin
      if (wr_at(wr_en, PADDR, cwc_pkg::OFF_BTC)) begin
        btc_r <= PWDATA[3:0];
      end
      if (wr_at(wr_en, PADDR, cwc_pkg::OFF_RLD)) begin
        reload_r <= PWDATA[15:0];
      end
    end
  end

  // Trigger divide counts, present for channels six and seven only
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      div6_r <= cwc_pkg::DIV_RST;
      div7_r <= cwc_pkg::DIV_RST;
    end else begin
      if (wr_at(wr_en, PADDR, cwc_pkg::OFF_DIV6)) begin
        div6_r <= PWDATA[7:0];
      end
      if (wr_at(wr_en, PADDR, cwc_pkg::OFF_DIV7)) begin
        div7_r <= PWDATA[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Base timer
  // ------------------------------------------------------------
  // A clear source counts only when it is the sole bit set; the
  // alternate source lies outside this block, so it means free run
  assign run = btc_r[cwc_pkg::BTC_RUN];
  assign sel_ch0 = btc_r[cwc_pkg::BTC_CH0] & ~btc_r[cwc_pkg::BTC_ALT]
    & ~btc_r[cwc_pkg::BTC_RLDM];
  assign sel_rld = btc_r[cwc_pkg::BTC_RLDM] & ~btc_r[cwc_pkg::BTC_ALT]
    & ~btc_r[cwc_pkg::BTC_CH0];
  assign tmr_hit = (sel_ch0 && cnt_r == cmp_act_r[0])
    || (sel_rld && cnt_r == reload_r);

  // Clear lands one count after the match: counts 0..n+1
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      clr_pend_r <= 1'b0;
    end else if (run) begin
      clr_pend_r <= tmr_hit;
    end
  end

  // Sixteen-bit wrap gives the free-running period
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_r <= 16'h0000;
    end else if (run) begin
      if (clr_pend_r) begin
        cnt_r <= 16'h0000;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Channel slices
  // ------------------------------------------------------------
  for (genvar g = 0; g < cwc_pkg::NCH; g++) begin : g_ch
    // Compare buffer and active value; capture overwrites both
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        cmp_buf_r[g] <= cwc_pkg::CMP_RST;
        cmp_act_r[g] <= cwc_pkg::CMP_RST;
      end else if (chb[g].cap) begin
        cmp_buf_r[g] <= cnt_r;
        cmp_act_r[g] <= cnt_r;
      end else if (wr_en && in_bank(PADDR, cwc_pkg::OFF_CMP0)
          && idx == 3'(g)) begin
        cmp_buf_r[g] <= PWDATA[15:0];
        if (!cfg_r[g][cwc_pkg::CFG_REFRESH]) begin
          cmp_act_r[g] <= PWDATA[15:0];
        end
      end else if (cfg_r[g][cwc_pkg::CFG_REFRESH]
          && cnt_r == 16'h0000) begin
        cmp_act_r[g] <= cmp_buf_r[g];
      end
    end

    // Output and capture control; unused bits stay zero
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        cfg_r[g] <= cwc_pkg::CFG_RST;
      end else if (wr_en && in_bank(PADDR, cwc_pkg::OFF_CFG0)
          && idx == 3'(g)) begin
        cfg_r[g] <= PWDATA[15:0] & cwc_pkg::CFG_MASK;
      end
    end

    assign chb[g].cnt = cnt_r;
    assign chb[g].cmp = cmp_act_r[g];
    assign chb[g].cfg = cfg_r[g];
    assign chb[g].fsel = fsel_r[g];
    assign chb[g].en = fen_r[g];
    assign chb[g].trig = TRIGGER_INPUT_PIN[g];
    assign match[g] = chb[g].match;
    assign evt[g] = chb[g].evt;
    assign WAVE_OUTPUT_PIN[g] = chb[g].out;

    // Set/reset pairs: even channel sets, the odd partner resets
    if (g % 2 == 0) begin : g_even
      assign chb[g].pmatch = match[g+1];
    end else begin : g_odd
      assign chb[g].pmatch = 1'b0;
    end

    if (g == 6) begin : g_div6
      assign chb[g].div = div6_r;
    end else if (g == 7) begin : g_div7
      assign chb[g].div = div7_r;
    end else begin : g_nodiv
      assign chb[g].div = 8'h00;
    end

    cwc_chan #(
      .HAS_DIV(g >= 6)
    ) u_chan (
      .clk(CLK),
      .rst_n(RESETN),
      .chb(chb[g])
    );
  end

  // ------------------------------------------------------------
  // Interrupt requests
  // ------------------------------------------------------------
  cwc_irq u_irq (
    .clk(CLK),
    .rst_n(RESETN),
    .set(evt),
    .clr_we(wr_at(wr_en, PADDR, cwc_pkg::OFF_IRQF)),
    .mask_we(wr_at(wr_en, PADDR, cwc_pkg::OFF_IMSK)),
    .wdata(PWDATA[7:0]),
    .flags(flags),
    .mask(mask),
    .irq(irq_w)
  );

  assign IRQ = irq_w;
endmodule
`default_nettype wire

// ==== inc/cwc_pkg.sv ====
// Purpose: Shared constants for the compare waveform channel block
// Assumes: APB word registers, 16-bit base timer, eight channels
// Notes:   Every offset and field position, and the writable registers' reset values, live here
package cwc_pkg;
  localparam int NCH = 8;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CMP0 = 8'h00; // channel_compare_value 0..7
  localparam logic [7:0] OFF_CFG0 = 8'h20; // channel_output_control 0..7
  localparam logic [7:0] OFF_FSEL = 8'h40; // function_select_reg
  localparam logic [7:0] OFF_FEN = 8'h44; // function_enable_reg
  localparam logic [7:0] OFF_IRQF = 8'h48; // interrupt_request_reg
  localparam logic [7:0] OFF_IMSK = 8'h4c;
  localparam logic [7:0] OFF_BTC = 8'h50; // base timer clear control
  localparam logic [7:0] OFF_RLD = 8'h54; // base_timer_reload_value
  localparam logic [7:0] OFF_DIV6 = 8'h58; // trigger_divide_count 6
  localparam logic [7:0] OFF_DIV7 = 8'h5c; // trigger_divide_count 7
  localparam logic [7:0] OFF_CNT = 8'h60; // base timer count, read only
  // ------------------------------------------------------------
  // Channel configuration fields
  // ------------------------------------------------------------
  localparam int CFG_SHAPE = 0; // wave_shape_sel, two bits
  localparam int CFG_IVL = 2; // initial_level_sel
  localparam int CFG_REFRESH = 3; // compare_refresh_timing
  localparam int CFG_FLIP = 4; // polarity_flip
  localparam int CFG_EDGE = 8; // trigger_edge_sel, two bits
  localparam int CFG_FILT = 10; // input_filter_sel, two bits
  localparam int CFG_GATE = 12; // gate_enable
  localparam int CFG_GCLR = 13; // gate_clear_on_match
  localparam int CFG_GAUX = 14; // gate_aux_sel
  localparam int CFG_DIV = 15; // divider_enable
  localparam logic [15:0] CFG_MASK = 16'hff1f;
  // ------------------------------------------------------------
  // Base timer clear control fields
  // ------------------------------------------------------------
  localparam int BTC_CH0 = 0; // clear_on_ch0_match
  localparam int BTC_ALT = 1; // clear_alt_source
  localparam int BTC_RLDM = 2; // clear_on_reload_match
  localparam int BTC_RUN = 3; // base timer counts while set
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [3:0] BTC_RST = 4'h8;
  localparam logic [15:0] RLD_RST = 16'hffff;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  typedef enum logic [1:0] {
    SHAPE_SINGLE = 2'b00,
    SHAPE_PHASE = 2'b01,
    SHAPE_SR = 2'b10
  } cwc_shape_t;
  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10
  } cwc_edge_t;
endpackage

// ==== inc/cwc_ch_if.sv ====
// Purpose: Carrier between the top and one channel slice
// Assumes: Single clock domain
// Notes:   Top drives timer and setup, channel answers with events
`timescale 1ns/1ns
`default_nettype none
interface cwc_ch_if;
  logic [15:0] cnt;
  logic [15:0] cmp;
  logic [15:0] cfg;
  logic [7:0] div;
  logic fsel;
  logic en;
  logic pmatch;
  logic trig;
  logic match;
  logic cap;
  logic evt;
  logic out;
  modport top (output cnt, cmp, cfg, div, fsel, en, pmatch, trig,
    input match, cap, evt, out);
  modport ch (input cnt, cmp, cfg, div, fsel, en, pmatch, trig,
    output match, cap, evt, out);
endinterface
`default_nettype wire

// ==== hdl/cwc_irq.sv ====
// Purpose: Sticky channel_irq_flag bits, mask and one level interrupt
// Assumes: Write-one-to-clear from software
// Notes:   A set in the clearing cycle survives
`timescale 1ns/1ns
`default_nettype none
module cwc_irq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] set,
  input wire logic clr_we,
  input wire logic mask_we,
  input wire logic [7:0] wdata,
  output logic [7:0] flags,
  output logic [7:0] mask,
  output logic irq
);
  logic [7:0] flags_nxt;
  logic [7:0] mask_nxt;

  // Set wins over a clear arriving in the same cycle
  always_comb begin
    flags_nxt = (flags & ~(clr_we ? wdata : 8'h00)) | set;
    mask_nxt = mask_we ? wdata : mask;
  end

  // Flag and mask storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= cwc_pkg::BYTE_RST;
      mask <= cwc_pkg::BYTE_RST;
    end else begin
      flags <= flags_nxt;
      mask <= mask_nxt;
    end
  end

  // Output flop tracks the next status so it never lags the flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_nxt & mask_nxt);
    end
  end
endmodule
`default_nettype wire

// ==== hdl/cwc_chan.sv ====
// Purpose: One channel: compare match, waveform level, capture trigger
// Assumes: Trigger pin already synchronous to the clock
// Notes:   Divider exists only where HAS_DIV is set
`timescale 1ns/1ns
`default_nettype none
module cwc_chan #(
  parameter bit HAS_DIV = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  cwc_ch_if.ch chb
);
  logic wave;
  logic meas;
  logic initial_level_sel;
  logic lvl_r;
  logic lvl_nxt;
  logic trig_d_r;
  logic edge_hit;
  logic tick;
  logic use_div;
  logic [7:0] pcnt_r;
  logic [1:0] shape;

  // ------------------------------------------------------------
  // Match and routing
  // ------------------------------------------------------------
  assign wave = chb.en & ~chb.fsel;
  assign meas = chb.en & chb.fsel;
  assign initial_level_sel = chb.cfg[cwc_pkg::CFG_IVL];
  assign shape = chb.cfg[cwc_pkg::CFG_SHAPE +: 2];
  assign chb.match = wave & (chb.cnt == chb.cmp);
  assign chb.evt = chb.match | chb.cap;

  // Next level: disabled slices park at the initial level
  always_comb begin
    lvl_nxt = lvl_r;
    if (!wave) begin
      lvl_nxt = initial_level_sel;
    end else begin
      case (shape)
        cwc_pkg::SHAPE_SINGLE: begin
          if (chb.match) begin
            lvl_nxt = ~initial_level_sel;
          end else if (chb.cnt == 16'h0000) begin
            lvl_nxt = initial_level_sel;
          end
        end
        cwc_pkg::SHAPE_PHASE: begin
          if (chb.match) begin
            lvl_nxt = ~lvl_r;
          end
        end
        cwc_pkg::SHAPE_SR: begin
          if (chb.match) begin
            lvl_nxt = ~initial_level_sel;
          end else if (chb.pmatch) begin
            lvl_nxt = initial_level_sel;
          end
        end
        default: lvl_nxt = lvl_r;
      endcase
    end
  end

  // Level one cycle behind the match, so default width is m clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_r <= 1'b0;
      chb.out <= 1'b0;
    end else begin
      lvl_r <= lvl_nxt;
      chb.out <= lvl_nxt ^ chb.cfg[cwc_pkg::CFG_FLIP];
    end
  end

  // ------------------------------------------------------------
  // Capture trigger
  // ------------------------------------------------------------
  // Last trigger level for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_d_r <= 1'b0;
    end else begin
      trig_d_r <= chb.trig;
    end
  end

  // Edge choice; code 11 accepts no trigger
  always_comb begin
    case (chb.cfg[cwc_pkg::CFG_EDGE +: 2])
      cwc_pkg::EDGE_RISE: edge_hit = chb.trig & ~trig_d_r;
      cwc_pkg::EDGE_FALL: edge_hit = ~chb.trig & trig_d_r;
      cwc_pkg::EDGE_BOTH: edge_hit = chb.trig ^ trig_d_r;
      default: edge_hit = 1'b0;
    endcase
  end

  assign tick = meas & edge_hit;
  assign use_div = HAS_DIV & chb.cfg[cwc_pkg::CFG_DIV];
  // Capture on every trigger, or on every divide count plus one
  assign chb.cap = tick & (~use_div | (pcnt_r == chb.div));

  // Trigger counter restarts whenever measuring stops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pcnt_r <= 8'h00;
    end else if (!meas || !use_div) begin
      pcnt_r <= 8'h00;
    end else if (tick) begin
      pcnt_r <= (pcnt_r == chb.div) ? 8'h00 : pcnt_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== verification/cwc_properties.sv ====
// Purpose: Port-level checks of the compare waveform block
// Assumes: One clock; APB slave answering in one access cycle
// Notes:   Shadows of enable, mask and idle level follow APB writes
`timescale 1ns/1ns
`default_nettype none
module cwc_properties (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [7:0] TRIGGER_INPUT_PIN,
  input wire logic [7:0] WAVE_OUTPUT_PIN,
  input wire logic IRQ
);
  logic wr_ok;
  logic [1:0] wr_cnt_r;
  logic [7:0] en_r;
  logic [7:0] mask_r;
  logic [7:0] idle_r;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // ----------------------------------------
  // Shadow state
  // ----------------------------------------
  // Committed write, an error reply means it was dropped
  assign wr_ok = PSEL && PENABLE && PWRITE && PREADY && !PSLVERR;
  // Settling window: outputs lag a write by up to two edges
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_cnt_r <= 2'h0;
    end else if (wr_ok) begin
      wr_cnt_r <= 2'h3;
    end else if (wr_cnt_r != 2'h0) begin
      wr_cnt_r <= wr_cnt_r - 2'h1;
    end
  end
  // Enable and mask copies
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      en_r <= 8'h00;
      mask_r <= 8'h00;
    end else if (wr_ok && PADDR == cwc_pkg::OFF_FEN) begin
      en_r <= PWDATA[7:0];
    end else if (wr_ok && PADDR == cwc_pkg::OFF_IMSK) begin
      mask_r <= PWDATA[7:0];
    end
  end
  // Idle pin level per channel: initial level after the flip
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      idle_r <= 8'h00;
    end else if (wr_ok && PADDR[7:5] == 3'b001) begin
      idle_r[PADDR[4:2]] <= PWDATA[2] ^ PWDATA[4];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  ready_in_access_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access phase");
  misaligned_err_a: assert property (PSEL && !PENABLE &&
    PADDR[1:0] != 2'b00 |=> PSLVERR && PREADY)
    else $error("misaligned access not refused");
  unmapped_err_a: assert property (PSEL && !PENABLE && PADDR > 8'h60
    |=> PSLVERR)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (PSEL && !PENABLE && PADDR <= 8'h60 &&
    PADDR[1:0] == 2'b00 |=> !PSLVERR)
    else $error("mapped access refused");
  err_reads_zero_a: assert property (PREADY && PSLVERR && !PWRITE
    |-> PRDATA == 32'h0)
    else $error("refused read returned data");
  idle_level_a: assert property (wr_cnt_r == 2'h0 |->
    ((WAVE_OUTPUT_PIN ^ idle_r) & ~en_r) == 8'h00)
    else $error("disabled channel pin not at idle level");
  irq_masked_a: assert property (wr_cnt_r == 2'h0 && mask_r == 8'h00
    |-> !IRQ)
    else $error("interrupt with all sources masked");
endmodule
`default_nettype wire

// ==== verification/tb_compare_waveform_channels.sv ====
// Purpose: Self-checking bench for the compare waveform block
// Assumes: APB master here; counts measured at the falling edge
// Notes:   Periods stay short by clearing the timer on a match
`timescale 1ns/1ns
`default_nettype none
module tb_compare_waveform_channels;
  logic CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, err;
  logic [7:0] PADDR, trig, wave;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [31:0] seed = 32'h2075d9bd;
  logic initial_level_sel, flip, d;
  int n_mismatch = 0, cmp_count = 0;
  int k, i, j, n, m, ci, cd;
  cwc_top i_cwc_top (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TRIGGER_INPUT_PIN(trig), .WAVE_OUTPUT_PIN(wave), .IRQ(IRQ));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], ^(x & 32'h80200003)};
  endfunction
  // Register of channel c in a bank of word registers
  function automatic logic [7:0] at(input logic [7:0] b, input int c);
    return b + 8'(4 * c);
  endfunction
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task test_done;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tmo(input string s);
    n_mismatch++;
    $display("unexpected %s: expected response, seen timeout", s);
    test_done;
  endtask
  // One APB transfer; holds the request until PREADY is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    int t;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (t = 0; t < 16; t++) begin
      @(posedge CLK);
      if (PREADY === 1'b1) break;
    end
    if (t == 16) tmo("pready");
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rv(input logic [7:0] a, input logic [31:0] e,
    input string s);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask
  // Falling edges until pin c shows level l, bounded
  task automatic wait_lvl(input int c, input logic l, output int cnt);
    cnt = 0;
    while (wave[c] !== l) begin
      @(negedge CLK);
      cnt++;
      if (cnt > 600) tmo("wave level");
    end
  endtask
  // Trigger pulse on channels 6 and 7, the other pins toggle at random
  task automatic pulse;
    seed = lfsr(seed);
    @(posedge CLK);
    trig <= seed[7:0] | 8'hc0;
    repeat (3) @(posedge CLK);
    trig <= seed[15:8] & 8'h3f;
    repeat (3) @(posedge CLK);
  endtask
  // ----------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  initial begin
    RESETN = 1'b0;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    trig = 8'h00;
    repeat (12) @(posedge CLK);
    RESETN <= 1'b1;
    rv(cwc_pkg::OFF_CFG0, 32'(cwc_pkg::CFG_RST), "cfg reset");
    rv(cwc_pkg::OFF_BTC, 32'(cwc_pkg::BTC_RST), "timer ctl reset");
    rv(cwc_pkg::OFF_RLD, 32'(cwc_pkg::RLD_RST), "reload reset");
    rv(cwc_pkg::OFF_DIV6, 32'(cwc_pkg::DIV_RST), "divider reset");
    rv(cwc_pkg::OFF_FEN, 32'h0, "enable reset");
    apb(1'b0, 8'h64, 32'h0);
    chk("unmapped slverr", 32'h1, 32'(err));
    chk("unmapped read", 32'h0, rd);
    apb(1'b1, 8'h42, 32'hff);
    chk("misaligned slverr", 32'h1, 32'(err));
    rv(cwc_pkg::OFF_FSEL, 32'h0, "function select kept");
    $display("test registers done");
    // Growing n keeps the count below each new clear point
    // Pass 3 sets the refresh bit only after its compare write, pass 4 toggles on each match
    for (k = 0; k < 5; k++) begin
      seed = lfsr(seed);
      n = 64 + 48 * k + int'(seed[4:0]);
      m = 1 + int'(seed[15:8]) % n;
      j = 1 + int'(seed[18:16]) % 7;
      initial_level_sel = seed[24];
      flip = seed[25];
      d = initial_level_sel ^ flip;
      apb(1'b1, cwc_pkg::OFF_BTC, k[0] ? 32'h9 : 32'hc);
      apb(1'b1, k[0] ? cwc_pkg::OFF_CMP0 : cwc_pkg::OFF_RLD, n);
      apb(1'b1, at(cwc_pkg::OFF_CMP0, j), m);
      apb(1'b1, at(cwc_pkg::OFF_CFG0, j),
        {flip, k == 3, initial_level_sel, 1'b0, k == 4});
      apb(1'b1, cwc_pkg::OFF_FSEL, 32'h0);
      apb(1'b1, cwc_pkg::OFF_FEN, (32'h1 << j) | 32'(k[0]));
      // One spare period after enable passes before the widths are counted
      repeat (2) begin
        wait_lvl(j, d, ci);
        wait_lvl(j, !d, ci);
      end
      wait_lvl(j, d, ci);
      wait_lvl(j, !d, cd);
      chk("inverse width", k == 4 ? n + 2 : n + 2 - m, ci);
      chk("default width", k == 4 ? n + 2 : m, cd);
      apb(1'b0, cwc_pkg::OFF_IRQF, 32'h0);
      chk("match flag", 32'h1, 32'(rd[j]));
      chk("irq masked", 32'h0, 32'(IRQ));
      apb(1'b1, cwc_pkg::OFF_IMSK, 32'h1 << j);
      repeat (2) @(negedge CLK);
      chk("irq raised", 32'h1, 32'(IRQ));
      apb(1'b1, cwc_pkg::OFF_FEN, 32'h0);
      repeat (3) @(negedge CLK);
      apb(1'b1, cwc_pkg::OFF_IRQF, 32'hff);
      apb(1'b0, cwc_pkg::OFF_IRQF, 32'h0);
      chk("flags after clear", 32'h0, rd);
      chk("irq after clear", 32'h0, 32'(IRQ));
      chk("idle pin", 32'(d), 32'(wave[j]));
      apb(1'b1, cwc_pkg::OFF_IMSK, 32'h0);
    end
    // Set/reset pair: channel 0 rises on its match, channel 1 drops it
    seed = lfsr(seed);
    m = 10 + int'(seed[5:0]);
    n = m + 1 + int'(seed[13:8]);
    apb(1'b1, cwc_pkg::OFF_CMP0, m);
    apb(1'b1, at(cwc_pkg::OFF_CMP0, 1), n);
    apb(1'b1, cwc_pkg::OFF_CFG0, 32'h2);
    apb(1'b1, cwc_pkg::OFF_FEN, 32'h3);
    repeat (2) begin
      wait_lvl(0, 1'b0, ci);
      wait_lvl(0, 1'b1, ci);
    end
    wait_lvl(0, 1'b0, ci);
    chk("set/reset width", n - m, ci);
    apb(1'b1, cwc_pkg::OFF_FEN, 32'h0);
    $display("test waveform done");
    apb(1'b1, cwc_pkg::OFF_FSEL, 32'hc0);
    apb(1'b1, cwc_pkg::OFF_DIV6, 32'h2);
    apb(1'b1, cwc_pkg::OFF_DIV7, 32'h2);
    apb(1'b1, at(cwc_pkg::OFF_CFG0, 6), 32'h8000);
    apb(1'b1, at(cwc_pkg::OFF_CFG0, 7), 32'h8100);
    apb(1'b1, cwc_pkg::OFF_FEN, 32'hc0);
    // Channel 6 counts rising edges, channel 7 falling ones
    for (i = 1; i <= 3; i++) begin
      pulse;
      apb(1'b0, cwc_pkg::OFF_IRQF, 32'h0);
      chk("capture flags", i == 3 ? 32'hc0 : 32'h0, rd & 32'hc0);
    end
    apb(1'b1, cwc_pkg::OFF_FEN, 32'h0);
    $display("test capture done");
    test_done;
  end
endmodule
bind cwc_top cwc_properties i_cwc_properties (.CLK(CLK),
  .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .TRIGGER_INPUT_PIN(TRIGGER_INPUT_PIN),
  .WAVE_OUTPUT_PIN(WAVE_OUTPUT_PIN), .IRQ(IRQ));
`default_nettype wire
